// ### mic_map.vh
// Purpose: register offsets, field positions and reset values of the
//          interrupt controller.
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register.
// Notes:   definitions only.
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// register byte offsets
`define MIC_CTRL_OFF      8'h00
`define MIC_EN_OFF        8'h04
`define MIC_FLAG_OFF      8'h08
`define MIC_FLAG_CLR_OFF  8'h0C
`define MIC_FLAG_SET_OFF  8'h10
`define MIC_TMR_EN_OFF    8'h14
`define MIC_TMR_FLAG_OFF  8'h18
`define MIC_TMR_CLR_OFF   8'h1C
`define MIC_STATUS_OFF    8'h20
`define MIC_VEC_OFF       8'h24

// control register fields
`define MIC_CTRL_GIE_BIT  0

// source bit positions in flag and enable words
`define MIC_SRC_SER       0
`define MIC_SRC_CONV      1
`define MIC_SRC_LVS       2
`define MIC_SRC_NVM       3
`define MIC_SRC_GRP0      4
`define MIC_SRC_GRP1      5
`define MIC_NSRC          6

// vector codes, one per source
`define MIC_VEC_SER       3'h1
`define MIC_VEC_CONV      3'h2
`define MIC_VEC_LVS       3'h3
`define MIC_VEC_NVM       3'h4
`define MIC_VEC_GRP0      3'h5
`define MIC_VEC_GRP1      3'h6

// reset values
`define MIC_CTRL_RST      1'h0
`define MIC_EN_RST        6'h00
`define MIC_FLAG_RST      6'h00

// axi responses
`define MIC_RESP_OKAY     2'h0
`define MIC_RESP_SLVERR   2'h2

`endif

// ### mic_ctrl.v
// Purpose: interrupt request, vectoring and wake-up logic of an 8-bit
//          controller, with an AXI4-Lite register slave.
// Assumes: one clock aclk, synchronous active-low reset, source event
//          inputs are one-cycle pulses synchronous to aclk.
// Notes:   timer modules are split over the two groups, the lower half
//          in group 0 and the upper half in group 1.
//
// How it works
// - serial flag sets on byte done, address match or time-out
// - vector only with global enable, source enable, stack room, flag set
// - serial service clears its flag and global enable
// - converter flag sets when a conversion finishes
// - converter service clears its flag and global enable
// - low-supply flag sets when the supply monitor reports low
// - low-supply service clears its flag and global enable
// - nonvolatile flag sets when a write cycle ends
// - nonvolatile service clears its flag and global enable
// - two group flags set when a member timer flag becomes set with its timer match enable set
// - group service clears only group flag and global enable
// - each timer has period and A match flags with enables
// - timer vectors need global, timer and group enables, stack room
// - any flag rising wakes from sleep or idle, enables ignored
// - disabling stops servicing only; flags stay until serviced or cleared
// - entry pushes only the program counter
// - irq return sets global enable; plain return leaves it cleared
// - new requests still latch while global enable is cleared
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mic_map.vh"

module mic_ctrl #(
    parameter NTMR = 4
) (
    // clock and reset
    input  wire            aclk,
    input  wire            aresetn,
    // axi4-lite write address
    input  wire [7:0]      s_axi_awaddr,
    input  wire            s_axi_awvalid,
    output reg             s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]     s_axi_wdata,
    input  wire [3:0]      s_axi_wstrb,
    input  wire            s_axi_wvalid,
    output reg             s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]      s_axi_bresp,
    output reg             s_axi_bvalid,
    input  wire            s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]      s_axi_araddr,
    input  wire            s_axi_arvalid,
    output reg             s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]     s_axi_rdata,
    output reg  [1:0]      s_axi_rresp,
    output reg             s_axi_rvalid,
    input  wire            s_axi_rready,
    // peripheral events
    input  wire            ser_byte_done,
    input  wire            ser_addr_match,
    input  wire            ser_timeout,
    input  wire            conv_done,
    input  wire            low_supply,
    input  wire            nvm_write_done,
    input  wire [NTMR-1:0] tmr_period_match,
    input  wire [NTMR-1:0] tmr_a_match,
    // cpu core sequencer
    input  wire            stack_full,
    input  wire            vec_ack,
    input  wire            irq_return_instr,
    input  wire            plain_return_instr,
    input  wire            sleep_mode,
    output reg             vec_req,
    output reg  [2:0]      vec_code,
    output reg             push_pc,
    output reg             wake_up
);

    localparam NG   = NTMR / 2;
    localparam NSRC = `MIC_NSRC;

    // vector handshake states
    localparam ST_IDLE = 2'b01;
    localparam ST_REQ  = 2'b10;

    reg             global_irq_en;
    reg  [NSRC-1:0] src_en_reg;
    reg  [NSRC-1:0] src_flag_reg;
    reg  [NTMR-1:0] timer_period_match_en;
    reg  [NTMR-1:0] timer_a_match_en;
    reg  [NTMR-1:0] timer_period_match_flag;
    reg  [NTMR-1:0] timer_a_match_flag;
    reg  [1:0]      state_reg;
    reg  [2:0]      svc_src_reg;
    reg  [NSRC-1:0] flag_prev_reg;
    reg  [2*NTMR-1:0] tflag_prev_reg;

    // timer flags with new rising events this cycle
    wire [NTMR-1:0] tp_set = tmr_period_match & ~timer_period_match_flag;
    wire [NTMR-1:0] ta_set = tmr_a_match & ~timer_a_match_flag;

    // per-group: a member newly raised and enabled at timer level
    wire [NTMR-1:0] t_new = (tp_set & timer_period_match_en)
                          | (ta_set & timer_a_match_en);
    wire grp0_evt = |t_new[NG-1:0];
    wire grp1_evt = |t_new[NTMR-1:NG];

    wire [NSRC-1:0] src_evt;
    assign src_evt[`MIC_SRC_SER]  = ser_byte_done | ser_addr_match
                                  | ser_timeout;
    assign src_evt[`MIC_SRC_CONV] = conv_done;
    assign src_evt[`MIC_SRC_LVS]  = low_supply;
    assign src_evt[`MIC_SRC_NVM]  = nvm_write_done;
    assign src_evt[`MIC_SRC_GRP0] = grp0_evt;
    assign src_evt[`MIC_SRC_GRP1] = grp1_evt;

    // requests eligible for vectoring
    wire [NSRC-1:0] pend = src_flag_reg & src_en_reg;
    wire            can_vec = global_irq_en & ~stack_full;

    // fixed priority: lowest source index first
    reg  [2:0]      pick_code;
    reg  [2:0]      pick_src;
    reg             pick_any;
    always @* begin
        pick_any  = 1'b1;
        pick_code = 3'h0;
        pick_src  = 3'h0;
        if (pend[`MIC_SRC_SER]) begin
            pick_code = `MIC_VEC_SER;
            pick_src  = `MIC_SRC_SER;
        end else if (pend[`MIC_SRC_CONV]) begin
            pick_code = `MIC_VEC_CONV;
            pick_src  = `MIC_SRC_CONV;
        end else if (pend[`MIC_SRC_LVS]) begin
            pick_code = `MIC_VEC_LVS;
            pick_src  = `MIC_SRC_LVS;
        end else if (pend[`MIC_SRC_NVM]) begin
            pick_code = `MIC_VEC_NVM;
            pick_src  = `MIC_SRC_NVM;
        end else if (pend[`MIC_SRC_GRP0]) begin
            pick_code = `MIC_VEC_GRP0;
            pick_src  = `MIC_SRC_GRP0;
        end else if (pend[`MIC_SRC_GRP1]) begin
            pick_code = `MIC_VEC_GRP1;
            pick_src  = `MIC_SRC_GRP1;
        end else begin
            pick_any  = 1'b0;
        end
    end

    // ---- axi4-lite slave
    reg        aw_hold_reg;
    reg [7:0]  aw_addr_reg;
    reg        w_hold_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
    wire wr_full  = &w_strb_reg;
    wire [31:0] wv = w_data_reg;

    // write decode, only full-word writes take effect
    wire wr_ctrl  = do_write & wr_full & (aw_addr_reg == `MIC_CTRL_OFF);
    wire wr_en    = do_write & wr_full & (aw_addr_reg == `MIC_EN_OFF);
    wire wr_fclr  = do_write & wr_full & (aw_addr_reg == `MIC_FLAG_CLR_OFF);
    wire wr_fset  = do_write & wr_full & (aw_addr_reg == `MIC_FLAG_SET_OFF);
    wire wr_ten   = do_write & wr_full & (aw_addr_reg == `MIC_TMR_EN_OFF);
    wire wr_tclr  = do_write & wr_full & (aw_addr_reg == `MIC_TMR_CLR_OFF);

    reg wr_known;
    always @* begin
        if (aw_addr_reg == `MIC_CTRL_OFF)
            wr_known = 1'b1;
        else if (aw_addr_reg == `MIC_EN_OFF)
            wr_known = 1'b1;
        else if (aw_addr_reg == `MIC_FLAG_CLR_OFF)
            wr_known = 1'b1;
        else if (aw_addr_reg == `MIC_FLAG_SET_OFF)
            wr_known = 1'b1;
        else if (aw_addr_reg == `MIC_TMR_EN_OFF)
            wr_known = 1'b1;
        else if (aw_addr_reg == `MIC_TMR_CLR_OFF)
            wr_known = 1'b1;
        else
            wr_known = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_hold_reg    <= 1'b0;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MIC_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_hold_reg && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_hold_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_hold_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read side
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b1;
        if (s_axi_araddr == `MIC_CTRL_OFF)
            rd_val[`MIC_CTRL_GIE_BIT] = global_irq_en;
        else if (s_axi_araddr == `MIC_EN_OFF)
            rd_val[NSRC-1:0] = src_en_reg;
        else if (s_axi_araddr == `MIC_FLAG_OFF)
            rd_val[NSRC-1:0] = src_flag_reg;
        else if (s_axi_araddr == `MIC_FLAG_CLR_OFF)
            rd_val = 32'h00000000;
        else if (s_axi_araddr == `MIC_FLAG_SET_OFF)
            rd_val = 32'h00000000;
        else if (s_axi_araddr == `MIC_TMR_EN_OFF)
            rd_val[2*NTMR-1:0] = {timer_a_match_en, timer_period_match_en};
        else if (s_axi_araddr == `MIC_TMR_FLAG_OFF)
            rd_val[2*NTMR-1:0] = {timer_a_match_flag,
                                  timer_period_match_flag};
        else if (s_axi_araddr == `MIC_TMR_CLR_OFF)
            rd_val = 32'h00000000;
        else if (s_axi_araddr == `MIC_STATUS_OFF)
            rd_val[3:0] = {wake_up, vec_req, stack_full, sleep_mode};
        else if (s_axi_araddr == `MIC_VEC_OFF)
            rd_val[2:0] = svc_src_reg;
        else
            rd_ok = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `MIC_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            // data only after the address handshake, as the bus requires
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---- vectoring handshake with the sequencer
    wire svc = (state_reg == ST_REQ) & vec_ack;
    wire [NSRC-1:0] svc_clr = svc ? (6'h01 << svc_src_reg) : 6'h00;

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= ST_IDLE;
            vec_req     <= 1'b0;
            vec_code    <= 3'h0;
            svc_src_reg <= 3'h0;
            push_pc     <= 1'b0;
        end else begin
            push_pc <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (can_vec && pick_any) begin
                        state_reg   <= ST_REQ;
                        vec_req     <= 1'b1;
                        vec_code    <= pick_code;
                        svc_src_reg <= pick_src;
                    end
                end
                ST_REQ: begin
                    if (vec_ack) begin
                        state_reg <= ST_IDLE;
                        vec_req   <= 1'b0;
                        push_pc   <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    vec_req   <= 1'b0;
                end
            endcase
        end
    end

    // ---- global enable, source enables and flags
    // events win over clears so nothing raised in a clear cycle is lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            global_irq_en <= `MIC_CTRL_RST;
            src_en_reg    <= `MIC_EN_RST;
            src_flag_reg  <= `MIC_FLAG_RST;
        end else begin
            if (svc)
                global_irq_en <= 1'b0;
            else if (irq_return_instr)
                global_irq_en <= 1'b1;
            else if (wr_ctrl)
                global_irq_en <= wv[`MIC_CTRL_GIE_BIT];
            if (wr_en)
                src_en_reg <= wv[NSRC-1:0];
            src_flag_reg <= (src_flag_reg
                             & ~svc_clr
                             & ~(wr_fclr ? wv[NSRC-1:0] : 6'h00))
                            | (wr_fset ? wv[NSRC-1:0] : 6'h00)
                            | src_evt;
        end
    end

    // ---- timer module flags and enables, one slice per timer
    genvar gi;
    generate
        for (gi = 0; gi < NTMR; gi = gi + 1) begin : g_tmr
            always @(posedge aclk) begin
                if (!aresetn) begin
                    timer_period_match_en[gi]   <= 1'b0;
                    timer_a_match_en[gi]        <= 1'b0;
                    timer_period_match_flag[gi] <= 1'b0;
                    timer_a_match_flag[gi]      <= 1'b0;
                end else begin
                    if (wr_ten) begin
                        timer_period_match_en[gi] <= wv[gi];
                        timer_a_match_en[gi]      <= wv[NTMR+gi];
                    end
                    // group service leaves these untouched
                    if (tmr_period_match[gi])
                        timer_period_match_flag[gi] <= 1'b1;
                    else if (wr_tclr && wv[gi])
                        timer_period_match_flag[gi] <= 1'b0;
                    if (tmr_a_match[gi])
                        timer_a_match_flag[gi] <= 1'b1;
                    else if (wr_tclr && wv[NTMR+gi])
                        timer_a_match_flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---- wake-up on any flag rising, enables ignored
    // a flag already high before sleep gives no edge, so cannot wake
    wire [NSRC-1:0]   f_rise = src_flag_reg & ~flag_prev_reg;
    wire [2*NTMR-1:0] t_cur  = {timer_a_match_flag, timer_period_match_flag};
    wire [2*NTMR-1:0] t_rise = t_cur & ~tflag_prev_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_prev_reg  <= `MIC_FLAG_RST;
            tflag_prev_reg <= {2*NTMR{1'b0}};
            wake_up        <= 1'b0;
        end else begin
            flag_prev_reg  <= src_flag_reg;
            tflag_prev_reg <= t_cur;
            if (sleep_mode && ((|f_rise) || (|t_rise)))
                wake_up <= 1'b1;
            else if (!sleep_mode)
                wake_up <= 1'b0;
        end
    end

    // plain return changes nothing here: global enable stays as it is
    wire unused_ok = plain_return_instr;

endmodule
`default_nettype wire

// ### mic_ctrl_monitor.sv
// Purpose: assertions on the controller's cpu-side ports.
// Assumes: one clock aclk, synchronous active-low aresetn.
// Notes:   the bus side is judged by the bench.
`timescale 1ns/1ps
`default_nettype none

module mic_ctrl_monitor (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // cpu inputs
    input wire logic       stack_full,
    input wire logic       vec_ack,
    input wire logic       sleep_mode,
    // controller outputs
    input wire logic       vec_req,
    input wire logic [2:0] vec_code,
    input wire logic       push_pc,
    input wire logic       wake_up
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ack_push: assert property (vec_req && vec_ack |=> push_pc)
        else $error("no push after vector taken");
    a_push_once: assert property (push_pc |=> !push_pc)
        else $error("push longer than one cycle");
    a_push_cause: assert property (push_pc |-> $past(vec_ack))
        else $error("push without a taken vector");
    a_req_holds: assert property (
        vec_req && !vec_ack |=> vec_req && $stable(vec_code))
        else $error("vector request dropped or changed");
    a_ack_clears: assert property (vec_req && vec_ack |=> !vec_req)
        else $error("request kept after vector taken");
    a_stack_blocks: assert property (
        stack_full && !vec_req |=> !vec_req)
        else $error("vector raised with stack full");
    a_code_valid: assert property (
        vec_req |-> vec_code inside {[3'h1:3'h6]})
        else $error("vector code out of range");
    a_wake_clear: assert property (!sleep_mode [*2] |-> !wake_up)
        else $error("wake held outside sleep");
endmodule

bind mic_ctrl mic_ctrl_monitor u_mon (.aclk, .aresetn, .stack_full,
    .vec_ack, .sleep_mode, .vec_req, .vec_code, .push_pc, .wake_up);

`default_nettype wire

// ### mic_cpu_model.sv
// Purpose: cpu sequencer model that takes vectors and returns.
// Assumes: vec_req stands until acked.
// Notes:   ack delay and return kind come from the bench.
`timescale 1ns/1ps
`default_nettype none

module mic_cpu_model (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // bench controls
    input  wire logic [1:0] lat,
    input  wire logic [1:0] ret_mode,
    // controller side
    input  wire logic       vec_req,
    input  wire logic       push_pc,
    output logic            vec_ack,
    output logic            irq_return_instr,
    output logic            plain_return_instr
);
    logic [1:0] wait_reg;
    logic [2:0] ret_reg;

    always @(posedge aclk) begin
        vec_ack            <= 1'b0;
        irq_return_instr   <= 1'b0;
        plain_return_instr <= 1'b0;
        if (!aresetn) begin
            wait_reg <= 2'h0;
            ret_reg  <= 3'h0;
        end else begin
            if (vec_req && !vec_ack) begin
                wait_reg <= wait_reg + 2'h1;
                if (wait_reg == lat) begin
                    vec_ack  <= 1'b1;
                    wait_reg <= 2'h0;
                end
            end
            // short service body with no calls, so the stack never grows
            if (push_pc) ret_reg <= 3'h4;
            else if (ret_reg != 3'h0) ret_reg <= ret_reg - 3'h1;
            if (ret_reg == 3'h1) begin
                irq_return_instr   <= (ret_mode == 2'h1);
                plain_return_instr <= (ret_mode == 2'h2);
            end
        end
    end
endmodule

`default_nettype wire

// ### tb_mic_ctrl.sv
// Purpose: self-checking bench for the interrupt controller.
// Assumes: cpu model acks vectors; bench drives the register bus.
// Notes:   fixed seed, so random picks repeat between runs.
`timescale 1ns/1ps
`default_nettype none
`include "mic_map.vh"

module tb_mic_ctrl;
    logic        aclk = 1'b0, aresetn = 1'b0, stack_full = 1'b0;
    logic        sleep_mode = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, tmr_p = 4'h0, tmr_a = 4'h0;
    logic [5:0]  ev = 6'h00;
    logic [1:0]  lat = 2'h0, ret_mode = 2'h1, s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, vec_req, push_pc, wake_up, vec_ack;
    logic        irq_return_instr, plain_return_instr;
    logic [2:0]  vec_code, codes[$];
    int          fails = 0, num_checks = 0, t, k;

    mic_ctrl #(.NTMR(4)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ser_byte_done(ev[0]),
        .ser_addr_match(ev[1]), .ser_timeout(ev[2]), .conv_done(ev[3]),
        .low_supply(ev[4]), .nvm_write_done(ev[5]), .tmr_period_match(tmr_p),
        .tmr_a_match(tmr_a), .stack_full, .vec_ack, .irq_return_instr,
        .plain_return_instr, .sleep_mode, .vec_req, .vec_code, .push_pc,
        .wake_up);
    mic_cpu_model cpu (.aclk, .aresetn, .lat, .ret_mode, .vec_req, .push_pc,
        .vec_ack, .irq_return_instr, .plain_return_instr);

    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (vec_req && vec_ack) codes.push_back(vec_code);
    end

    function automatic logic [2:0] src_code(input int b);
        return (b < 3) ? 3'h1 : 3'(b - 1);
    endfunction
    function automatic logic [2:0] grp_code(input int n);
        return (n < 2) ? `MIC_VEC_GRP0 : `MIC_VEC_GRP1;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `MIC_RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic fire(input int b);
        @(posedge aclk);
        ev[b] <= 1'b1;
        @(posedge aclk);
        ev[b] <= 1'b0;
    endtask

    // bounded wait for n taken vectors, then room for the return
    task automatic wait_vec(input int n);
        for (int i = 0; i < 300 && codes.size() < n; i++) @(posedge aclk);
        repeat (8) @(posedge aclk);
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        t = $urandom(32'h545A);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`MIC_FLAG_OFF, 32'h0, `MIC_RESP_OKAY);
        rd(8'h40, 32'h0, `MIC_RESP_SLVERR);
        wr(`MIC_FLAG_OFF, 32'h3F, `MIC_RESP_SLVERR);
        $display("test reset done");
        wr(`MIC_EN_OFF, 32'h3F);
        fire($urandom_range(0, 2));
        fire(5);
        fire(4);
        fire(3);
        rd(`MIC_FLAG_OFF, 32'hF, `MIC_RESP_OKAY);
        wr(`MIC_CTRL_OFF, 32'h1);
        wait_vec(4);
        for (k = 0; k < 4; k++) chk(codes[k], k + 1);
        rd(`MIC_FLAG_OFF, 32'h0, `MIC_RESP_OKAY);
        rd(`MIC_CTRL_OFF, 32'h1, `MIC_RESP_OKAY);
        $display("test priority done");
        ret_mode <= 2'h2;
        for (k = 0; k < 6; k++) begin
            lat <= 2'($urandom_range(0, 3));
            wr(`MIC_CTRL_OFF, 32'h1);
            fire(k);
            wait_vec(5 + k);
            chk(codes[4 + k], src_code(k));
            rd(`MIC_CTRL_OFF, 32'h0, `MIC_RESP_OKAY);
            rd(`MIC_FLAG_OFF, 32'h0, `MIC_RESP_OKAY);
        end
        $display("test sources done");
        stack_full <= 1'b1;
        wr(`MIC_CTRL_OFF, 32'h1);
        fire(5);
        repeat (20) @(posedge aclk);
        chk(vec_req, 1'b0);
        rd(`MIC_STATUS_OFF, 32'h2, `MIC_RESP_OKAY);
        stack_full <= 1'b0;
        wait_vec(11);
        chk(codes[10], `MIC_VEC_NVM);
        rd(`MIC_VEC_OFF, `MIC_SRC_NVM, `MIC_RESP_OKAY);
        wr(`MIC_EN_OFF, 32'h37);
        wr(`MIC_CTRL_OFF, 32'h1);
        fire(5);
        repeat (20) @(posedge aclk);
        chk(codes.size(), 11);
        rd(`MIC_FLAG_OFF, 32'h8, `MIC_RESP_OKAY);
        wr(`MIC_FLAG_CLR_OFF, 32'h8);
        rd(`MIC_FLAG_OFF, 32'h0, `MIC_RESP_OKAY);
        $display("test blocking done");
        wr(`MIC_TMR_EN_OFF, 32'hFF);
        wr(`MIC_EN_OFF, 32'h3F);
        for (k = 0; k < 4; k++) begin
            t = $urandom_range(0, 7);
            wr(`MIC_CTRL_OFF, 32'h1);
            if (t < 4) tmr_p[t] <= 1'b1;
            else tmr_a[t - 4] <= 1'b1;
            @(posedge aclk);
            tmr_p <= 4'h0;
            tmr_a <= 4'h0;
            wait_vec(12 + k);
            chk(codes[11 + k], grp_code(t % 4));
            rd(`MIC_FLAG_OFF, 32'h0, `MIC_RESP_OKAY);
            rd(`MIC_TMR_FLAG_OFF, 32'h1 << t, `MIC_RESP_OKAY);
            wr(`MIC_TMR_CLR_OFF, 32'hFF);
        end
        $display("test timers done");
        wr(`MIC_CTRL_OFF, 32'h0);
        sleep_mode <= 1'b1;
        fire(4);
        for (k = 0; k < 10 && wake_up !== 1'b1; k++) @(posedge aclk);
        chk(wake_up, 1'b1);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(wake_up, 1'b0);
        wr(`MIC_FLAG_SET_OFF, 32'h8);
        sleep_mode <= 1'b1;
        fire(5);
        repeat (10) @(posedge aclk);
        chk(wake_up, 1'b0);
        $display("test wake done");
        summarize();
    end
endmodule

`default_nettype wire
